// file: logic/serial_mux_consts.vh
`ifndef SERIAL_MUX_CONSTS_VH
`define SERIAL_MUX_CONSTS_VH
// register word offsets (address bits 2:1)
`define OFF_CTLSTAT  2'h0
`define OFF_RXPARAM  2'h1
`define OFF_TXCTL    2'h2
`define OFF_LINEDATA 2'h3
// control line codes {c1,c0}
`define MODE_RD      2'h0
`define MODE_RDB     2'h1
`define MODE_WR      2'h2
`define MODE_WRB     2'h3
// fixed pattern for address bits 17:15
`define ADDR_HI_PAT  3'h7
// control_and_status fields
`define CS_SCAN_BIT     5
`define CS_SWCLEAR_BIT  4
`define CS_RXIE_BIT     6
`define CS_RXDONE_BIT   7
`define CS_TXIE_BIT     14
`define CS_TXRDY_BIT    15
`define CS_WMASK        16'h4060
`define CS_RST          16'h0000
`define TXCTL_RST       16'h0000
`define BREAK_RST       8'h00
`define PARAM_RST       16'h0000
`define LINESTAT_RST    16'h0000
// vector offset of the transmitter vector
`define VEC_TX_OFF   9'h004
// master sync delay in cycles before address strobe
`define MSYN_DLY     2
`endif

// file: logic/serial_mux_host_bus_slave.v
`timescale 1ns/1ns
`include "serial_mux_consts.vh"
module serial_mux_host_bus_slave #(
  parameter CURRENT_LOOP = 0
) (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire [17:0] busAddr,
  input  wire [1:0]  busCtl,
  input  wire        msyn,
  output wire        ssyn,
  input  wire [15:0] dataIn,
  output wire [15:0] dataOut,
  output wire [1:0]  dataOeN,
  input  wire [11:0] baseSwitch,
  input  wire [8:0]  vectorSwitch,
  input  wire        rxIntReq,
  input  wire        txIntReq,
  input  wire        busBusy,
  input  wire        grantIn,
  output wire        grantOut,
  output wire        busRequest,
  output wire        sack,
  output wire        intr,
  input  wire        vecAck,
  input  wire [15:0] rxFifoData,
  input  wire        rxFifoValid,
  output wire        rxFifoPop,
  output wire [15:0] lineParam,
  output wire        lineParamLoad,
  output wire [7:0]  txChar,
  output wire        txCharValid,
  input  wire        txCharReady,
  output wire [7:0]  termReady,
  output wire [7:0]  lineEnable,
  input  wire [7:0]  uartSerialOut,
  output wire [7:0]  serialOut,
  input  wire [7:0]  ringIn,
  input  wire [7:0]  carrierIn,
  output wire        scanEnable,
  output wire        softwareClear
);

  // ***************************************************
  // address recognition and slave timing
  // ***************************************************
  reg  [`MSYN_DLY-1:0] msynDly_q;
  reg         ssyn_q;
  reg         busy_q;
  wire        msynLate;
  wire        sel;
  wire        access;

  // master sync must stand on the pin and in every delay stage
  assign msynLate = msyn & (&msynDly_q);
  assign sel = (busAddr[14:3] == baseSwitch) &
               (busAddr[17:15] == `ADDR_HI_PAT);
  assign access = msynLate & sel & ~busy_q;

  always @(posedge sys_clk) begin
    if (rst) begin
      msynDly_q <= {`MSYN_DLY{1'b0}};
      ssyn_q    <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      msynDly_q <= {msynDly_q[`MSYN_DLY-2:0], msyn};
      if (access) begin
        busy_q <= 1'b1;
        ssyn_q <= 1'b1;
      end else if (!msyn) begin
        busy_q <= 1'b0;
        ssyn_q <= 1'b0;
      end
    end
  end
  assign ssyn = ssyn_q;

  // ***************************************************
  // mode and register decode
  // ***************************************************
  wire        isWrite;
  wire        isByte;
  wire [1:0]  word;
  wire        rdCtlStat;
  wire        rdRxBuf;
  wire        rdTxCtl;
  wire        rdLineStat;
  wire        wrCtlStat;
  wire        wrParam;
  wire        wrTxCtl;
  wire        wrTxData;
  wire        isRead;
  wire [15:0] wMask;

  assign isWrite = (busCtl == `MODE_WR) | (busCtl == `MODE_WRB);
  assign isByte  = (busCtl == `MODE_WRB);
  assign isRead  = ~busCtl[1];
  assign word    = busAddr[2:1];

  // separate read and write decoders, one enabled per access
  assign rdCtlStat  = access & isRead & (word == `OFF_CTLSTAT);
  assign rdRxBuf    = access & isRead & (word == `OFF_RXPARAM);
  assign rdTxCtl    = access & isRead & (word == `OFF_TXCTL);
  assign rdLineStat = access & isRead & (word == `OFF_LINEDATA);
  assign wrCtlStat  = access & isWrite & (word == `OFF_CTLSTAT);
  assign wrParam    = access & isWrite & (word == `OFF_RXPARAM);
  assign wrTxCtl    = access & isWrite & (word == `OFF_TXCTL);
  // the current-loop build has no transmit data register to write
  assign wrTxData   = access & isWrite & (word == `OFF_LINEDATA) &
                      (CURRENT_LOOP == 0);

  // byte writes pick their lane from address bit 0
  assign wMask = ~isByte ? 16'hFFFF :
                 (busAddr[0] ? 16'hFF00 : 16'h00FF);

  // ***************************************************
  // registers
  // ***************************************************
  reg  [15:0] ctlStat_q;
  reg  [15:0] txCtl_q;
  reg  [7:0]  break_q;
  reg  [15:0] param_q;
  reg         paramLoad_q;
  reg         swClear_q;
  reg  [15:0] lineStat_q;
  wire [15:0] ctlStatRead;
  wire [15:0] txCtlRead;
  wire        bufInReady;
  wire        swClearReq;

  // bit 15 shows room in the character buffer, bit 7 a waiting receive entry
  assign ctlStatRead = {bufInReady, ctlStat_q[14:8], rxFifoValid, ctlStat_q[6:5],
                        1'b0, 4'h0};
  assign txCtlRead   = (CURRENT_LOOP != 0) ? {8'h00, txCtl_q[7:0]} : txCtl_q;
  assign swClearReq  = wrCtlStat & wMask[`CS_SWCLEAR_BIT] & dataIn[`CS_SWCLEAR_BIT];

  // software clear acts one cycle after the write that requests it
  always @(posedge sys_clk) begin
    if (rst) begin
      swClear_q <= 1'b0;
    end else begin
      swClear_q <= swClearReq;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      ctlStat_q <= `CS_RST;
    end else if (swClear_q) begin
      ctlStat_q <= `CS_RST;
    end else if (wrCtlStat) begin
      ctlStat_q <= (ctlStat_q & ~(wMask & `CS_WMASK)) |
                   (dataIn & wMask & `CS_WMASK);
    end
  end

  // terminal ready survives software clear, line enables do not
  always @(posedge sys_clk) begin
    if (rst) begin
      txCtl_q <= `TXCTL_RST;
    end else if (swClear_q) begin
      txCtl_q[7:0] <= 8'h00;
    end else if (wrTxCtl) begin
      txCtl_q <= (txCtl_q & ~wMask) | (dataIn & wMask);
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      break_q <= `BREAK_RST;
    end else if (swClear_q) begin
      break_q <= `BREAK_RST;
    end else if (wrTxData & wMask[8]) begin
      break_q <= dataIn[15:8];
    end
  end

  // line parameters ignore software clear
  always @(posedge sys_clk) begin
    if (rst) begin
      param_q     <= `PARAM_RST;
      paramLoad_q <= 1'b0;
    end else begin
      paramLoad_q <= wrParam;
      if (wrParam) begin
        param_q <= (param_q & ~wMask) | (dataIn & wMask);
      end
    end
  end

  // line status sampled every cycle, only reset clears it
  always @(posedge sys_clk) begin
    if (rst) begin
      lineStat_q <= `LINESTAT_RST;
    end else begin
      lineStat_q <= {carrierIn, ringIn};
    end
  end

  assign softwareClear = swClear_q;
  assign scanEnable    = ctlStat_q[`CS_SCAN_BIT];
  assign lineParam     = param_q;
  assign lineParamLoad = paramLoad_q;
  assign termReady     = (CURRENT_LOOP != 0) ? 8'h00 : txCtl_q[15:8];
  assign lineEnable    = txCtl_q[7:0];
  assign rxFifoPop     = rdRxBuf & rxFifoValid;

  // ***************************************************
  // per-line break gating
  // ***************************************************
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gLine
      assign serialOut[g] = uartSerialOut[g] & ~break_q[g];
    end
  endgenerate

  // ***************************************************
  // two-entry transmit character buffer
  // ***************************************************
  reg  [7:0]  bufData_q [0:1];
  reg         wrPtr_q;
  reg         rdPtr_q;
  reg  [1:0]  count_q;
  wire        push;
  wire        pop;

  // a full buffer turns away further characters; status bit 15 warns software
  assign bufInReady  = (count_q != 2'h2);
  assign txCharValid = (count_q != 2'h0);
  assign txChar      = bufData_q[rdPtr_q];
  assign push        = wrTxData & wMask[0] & bufInReady & ~swClear_q;
  assign pop         = txCharValid & txCharReady;

  always @(posedge sys_clk) begin
    if (rst | swClear_q) begin
      wrPtr_q <= 1'b0;
    end else if (push) begin
      wrPtr_q <= ~wrPtr_q;
    end
  end

  always @(posedge sys_clk) begin
    if (rst | swClear_q) begin
      rdPtr_q <= 1'b0;
    end else if (pop) begin
      rdPtr_q <= ~rdPtr_q;
    end
  end

  always @(posedge sys_clk) begin
    if (rst | swClear_q) begin
      count_q <= 2'h0;
    end else begin
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always @(posedge sys_clk) begin
    if (push)
      bufData_q[wrPtr_q] <= dataIn[7:0];
  end

  // ***************************************************
  // interrupt request, grant and vector
  // ***************************************************
  localparam ST_IDLE = 2'd0;
  localparam ST_REQ  = 2'd1;
  localparam ST_ACK  = 2'd2;
  localparam ST_VEC  = 2'd3;

  reg  [1:0]  ist_q;
  reg  [1:0]  ist_d;
  reg         srcTx_q;
  reg         srcTx_d;
  wire        rxPend;
  wire        txPend;

  assign rxPend = rxIntReq & ctlStat_q[`CS_RXIE_BIT];
  assign txPend = txIntReq & ctlStat_q[`CS_TXIE_BIT];

  always @* begin
    ist_d   = ist_q;
    srcTx_d = srcTx_q;
    case (ist_q)
      ST_IDLE: begin
        if (rxPend | txPend) begin
          srcTx_d = ~rxPend;
          ist_d   = ST_REQ;
        end
      end
      ST_REQ: begin
        if (grantIn & ~ssyn_q)
          ist_d = ST_ACK;
      end
      ST_ACK: begin
        if (~grantIn & ~busBusy & ~ssyn_q)
          ist_d = ST_VEC;
      end
      ST_VEC: begin
        if (vecAck)
          ist_d = ST_IDLE;
      end
      default: ist_d = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      ist_q   <= ST_IDLE;
      srcTx_q <= 1'b0;
    end else begin
      ist_q   <= ist_d;
      srcTx_q <= srcTx_d;
    end
  end

  assign busRequest = (ist_q == ST_REQ);
  assign grantOut   = grantIn & (ist_q != ST_REQ) & (ist_q != ST_ACK);
  assign sack       = (ist_q == ST_ACK);
  assign intr       = (ist_q == ST_VEC);

  // ***************************************************
  // internal data bus and lane drivers
  // ***************************************************
  reg  [15:0] rdData_q;
  wire [8:0]  vecVal;
  wire [15:0] rdMux;

  assign vecVal = srcTx_q ? (vectorSwitch + `VEC_TX_OFF) : vectorSwitch;
  assign rdMux  = rdCtlStat  ? ctlStatRead :
                  rdRxBuf    ? rxFifoData :
                  rdTxCtl    ? txCtlRead :
                  rdLineStat ? ((CURRENT_LOOP != 0) ? 16'h0000 : lineStat_q) :
                  16'h0000;

  always @(posedge sys_clk) begin
    if (rst)
      rdData_q <= 16'h0000;
    else if (access & ~isWrite)
      rdData_q <= rdMux;
  end

  assign dataOut = intr ? {7'h00, vecVal} : rdData_q;
  // lanes driven during read slave sync; vector uses only its lanes
  assign dataOeN[0] = ~((ssyn_q & ~busCtl[1]) | intr);
  assign dataOeN[1] = ~((ssyn_q & ~busCtl[1]) | (intr & vecVal[8]));

endmodule

// file: tb/int_host_model.sv
`timescale 1ns/1ns
module int_host_model (
  input  wire        sys_clk,
  input  wire        busRequest,
  input  wire        sack,
  input  wire        intr,
  input  wire        stray,
  input  wire [15:0] dataOut,
  output reg         grantIn = 1'b0,
  output reg         vecAck = 1'b0,
  output reg  [15:0] vecSeen = 16'h0000,
  output reg         vecDone = 1'b0
);
  // grants a request until acknowledged; stray grants one nobody asked for
  always @(posedge sys_clk) begin
    grantIn <= (busRequest & ~sack & ~intr) | stray;
    vecAck <= intr & ~vecAck;
    vecDone <= intr & ~vecAck;
    if (intr & ~vecAck)
      vecSeen <= dataOut;
  end
endmodule

// file: tb/serial_mux_host_bus_slave_props.sv
`timescale 1ns/1ns
module serial_mux_host_bus_slave_props (
  input wire        sys_clk,
  input wire        rst,
  input wire [17:0] busAddr,
  input wire [1:0]  busCtl,
  input wire        msyn,
  input wire        ssyn,
  input wire [15:0] dataOut,
  input wire [1:0]  dataOeN,
  input wire [11:0] baseSwitch,
  input wire [8:0]  vectorSwitch,
  input wire        busBusy,
  input wire        grantIn,
  input wire        grantOut,
  input wire        busRequest,
  input wire        sack,
  input wire        intr,
  input wire [7:0]  uartSerialOut,
  input wire [7:0]  serialOut
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_addr_match: assert property (
    $rose(ssyn) |-> $past(busAddr[17:15]) == 3'h7 && $past(busAddr[14:3]) == $past(baseSwitch))
    else $error("sync for foreign address");
  a_sync_delay: assert property (
    $rose(ssyn) |-> $past(msyn) && $past(msyn, 2) && $past(msyn, 3))
    else $error("sync before delay");
  a_ssyn_release: assert property (
    ssyn && !msyn |=> !ssyn)
    else $error("sync held");
  a_read_drive: assert property (
    ssyn && !busCtl[1] |-> dataOeN == 2'h0)
    else $error("read lanes off");
  a_grant_pass: assert property (
    grantIn && !busRequest && !sack && !intr |-> grantOut)
    else $error("grant not passed");
  a_own_sack: assert property (
    busRequest && grantIn && !ssyn |=> sack)
    else $error("no acknowledge");
  a_intr_cond: assert property (
    $rose(intr) |-> $past(sack) && !$past(grantIn) && !$past(busBusy))
    else $error("early interrupt");
  a_vector_lanes: assert property (
    intr |-> dataOeN == {~dataOut[8], 1'b0} &&
      (dataOut[8:0] == vectorSwitch || dataOut[8:0] == vectorSwitch + 9'h004))
    else $error("bad vector");
  a_break_zero: assert property (
    (serialOut & ~uartSerialOut) == 8'h00)
    else $error("line not forced to space");
endmodule
bind serial_mux_host_bus_slave serial_mux_host_bus_slave_props props_i (
  .sys_clk(sys_clk), .rst(rst), .busAddr(busAddr), .busCtl(busCtl), .msyn(msyn),
  .ssyn(ssyn), .dataOut(dataOut), .dataOeN(dataOeN), .baseSwitch(baseSwitch),
  .vectorSwitch(vectorSwitch), .busBusy(busBusy), .grantIn(grantIn), .grantOut(grantOut),
  .busRequest(busRequest), .sack(sack), .intr(intr), .uartSerialOut(uartSerialOut),
  .serialOut(serialOut));

// file: tb/serial_mux_host_bus_slave_tb.sv
`timescale 1ns/1ns
module serial_mux_host_bus_slave_tb;
  reg         sys_clk = 1'b0, rst = 1'b1, msyn = 1'b0, busBusy = 1'b0, stray = 1'b0;
  reg         rxIntReq = 1'b0, txIntReq = 1'b0, rxFifoValid = 1'b0, txCharReady = 1'b0;
  reg  [17:0] busAddr = 18'h0_0000;
  reg  [1:0]  busCtl = 2'h0;
  reg  [15:0] dataIn = 16'h0000, rxFifoData = 16'h0000, rd;
  reg  [11:0] baseSwitch = 12'h123;
  reg  [8:0]  vectorSwitch = 9'h130;
  reg  [7:0]  uartSerialOut = 8'hFF, ringIn = 8'h00, carrierIn = 8'h00;
  wire        ssyn, grantIn, grantOut, busRequest, sack, intr, vecAck, vecDone;
  wire        rxFifoPop, lineParamLoad, txCharValid, scanEnable, softwareClear;
  wire [15:0] dataOut, lineParam, vecSeen;
  wire [1:0]  dataOeN;
  wire [7:0]  txChar, termReady, lineEnable, serialOut;
  reg  [36:0] rows [0:7];
  reg  [7:0]  txLog [0:3];
  reg         got;
  integer     miscompares = 0, samplesChecked = 0, cyc = 0, pops = 0, i, n;
  integer     txCount = 0, loads = 0;

  serial_mux_host_bus_slave serial_mux_host_bus_slave_i (
    .sys_clk(sys_clk), .rst(rst), .busAddr(busAddr), .busCtl(busCtl), .msyn(msyn),
    .ssyn(ssyn), .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN),
    .baseSwitch(baseSwitch), .vectorSwitch(vectorSwitch), .rxIntReq(rxIntReq),
    .txIntReq(txIntReq), .busBusy(busBusy), .grantIn(grantIn), .grantOut(grantOut),
    .busRequest(busRequest), .sack(sack), .intr(intr), .vecAck(vecAck),
    .rxFifoData(rxFifoData), .rxFifoValid(rxFifoValid), .rxFifoPop(rxFifoPop),
    .lineParam(lineParam), .lineParamLoad(lineParamLoad), .txChar(txChar),
    .txCharValid(txCharValid), .txCharReady(txCharReady), .termReady(termReady),
    .lineEnable(lineEnable), .uartSerialOut(uartSerialOut), .serialOut(serialOut),
    .ringIn(ringIn), .carrierIn(carrierIn), .scanEnable(scanEnable),
    .softwareClear(softwareClear));
  int_host_model int_host_model_i (
    .sys_clk(sys_clk), .busRequest(busRequest), .sack(sack), .intr(intr), .stray(stray),
    .dataOut(dataOut), .grantIn(grantIn), .vecAck(vecAck), .vecSeen(vecSeen),
    .vecDone(vecDone));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rxFifoPop === 1'b1) pops <= pops + 1;
    if (lineParamLoad === 1'b1) loads <= loads + 1;
    if (txCharValid === 1'b1 && txCharReady) begin
      if (txCount < 4) txLog[txCount] <= txChar;
      txCount <= txCount + 1;
    end
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      end_of_test;
    end
  end

  // ********************
  // bus tasks
  // ********************
  function [17:0] ab(input [2:0] o);
    ab = {3'h7, 12'h123, o};
  endfunction
  task acc(input [1:0] c, input [17:0] a, input [15:0] d);
    begin
      busCtl <= c;
      busAddr <= a;
      dataIn <= d;
      msyn <= 1'b1;
      got = 0;
      for (n = 0; n < 8 && !got; n = n + 1) begin
        @(posedge sys_clk);
        got = (ssyn === 1'b1);
        rd = dataOut;
      end
      msyn <= 1'b0;
      for (n = 0; n < 4 && ssyn !== 1'b0; n = n + 1)
        @(posedge sys_clk);
      @(posedge sys_clk);
    end
  endtask
  task chk(input [31:0] nm, input [15:0] e, input [15:0] g);
    begin
      samplesChecked = samplesChecked + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task waitVec;
    begin
      @(posedge sys_clk);
      for (n = 0; n < 40 && vecDone !== 1'b1; n = n + 1)
        @(posedge sys_clk);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", samplesChecked, miscompares);
      if (miscompares == 0 && samplesChecked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // ********************
  // sequence
  // ********************
  initial begin
    rows[0] = {2'h2, 3'h4, 16'hA55A, 16'h0000};
    rows[1] = {2'h0, 3'h4, 16'h0000, 16'hA55A};
    rows[2] = {2'h3, 3'h5, 16'h3C00, 16'h0000};
    rows[3] = {2'h3, 3'h4, 16'h00F0, 16'h0000};
    rows[4] = {2'h0, 3'h4, 16'h0000, 16'h3CF0};
    rows[5] = {2'h2, 3'h0, 16'hFFEF, 16'h0000};
    rows[6] = {2'h0, 3'h0, 16'h0000, 16'hC060};
    rows[7] = {2'h2, 3'h0, 16'h0000, 16'h0000};
    repeat (5) @(posedge sys_clk);
    chk("oen", 16'h0003, {14'h0000, dataOeN});
    chk("trdy", 16'h0000, {8'h00, termReady, lineEnable});
    rst <= 1'b0;
    @(posedge sys_clk);
    for (i = 0; i < 8; i = i + 1) begin
      acc(rows[i][36:35], ab(rows[i][34:32]), rows[i][31:16]);
      if (!rows[i][36]) chk("row", rows[i][15:0], rd);
    end
    chk("tctl", 16'h3CF0, {termReady, lineEnable});
    acc(2'h0, {3'h6, 12'h123, 3'h0}, 16'h0000);
    chk("hsel", 16'h0000, {15'h0000, got});
    acc(2'h0, {3'h7, 12'h124, 3'h0}, 16'h0000);
    chk("bsel", 16'h0000, {15'h0000, got});
    ringIn <= 8'hA5;
    carrierIn <= 8'h3C;
    acc(2'h0, ab(6), 16'h0000);
    chk("lsts", 16'h3CA5, rd);
    rxFifoData <= 16'h8123;
    rxFifoValid <= 1'b1;
    acc(2'h1, ab(2), 16'h0000);
    rxFifoValid <= 1'b0;
    chk("rxbf", 16'h8123, rd);
    chk("pop", 16'h0001, pops[15:0]);
    acc(2'h2, ab(2), 16'h1E35);
    chk("parm", 16'h1E35, lineParam);
    chk("pld", 16'h0001, loads[15:0]);
    for (i = 0; i < 3; i = i + 1)
      acc(2'h2, ab(6), 16'h0041 + i[15:0]);
    acc(2'h0, ab(0), 16'h0000);
    chk("full", 16'h0000, {15'h0000, rd[15]});
    txCharReady <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("txn", 16'h0002, txCount[15:0]);
    chk("txc", 16'h4142, {txLog[0], txLog[1]});
    acc(2'h3, ab(7), 16'h0500);
    chk("brk", 16'h00FA, {8'h00, serialOut});
    acc(2'h2, ab(0), 16'h0010);
    repeat (3) @(posedge sys_clk);
    chk("swcl", 16'h3C00, {termReady, lineEnable});
    chk("brk", 16'h00FF, {8'h00, serialOut});
    stray <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("gnt", 16'h0001, {15'h0000, grantOut});
    stray <= 1'b0;
    acc(2'h2, ab(0), 16'h4040);
    rxIntReq <= 1'b1;
    txIntReq <= 1'b1;
    waitVec;
    chk("vrx", 16'h0130, {7'h00, vecSeen[8:0]});
    rxIntReq <= 1'b0;
    waitVec;
    chk("vtx", 16'h0134, {7'h00, vecSeen[8:0]});
    txIntReq <= 1'b0;
    repeat (4) @(posedge sys_clk);
    end_of_test;
  end
endmodule
